// ===== src/qdsc_pkg.sv
// shared constants for the quad converter serial control link
package qdsc_pkg;
	localparam int         DATA_W       = 12;
	localparam int         NUM_CH       = 4;
	localparam logic [4:0] FRAME_BITS   = 5'h10;
	localparam logic [4:0] RD_START_CLK = 5'h05;
	localparam int         RW_BIT       = 15;
	localparam int         ADDR_MSB     = 14;
	localparam int         ADDR_LSB     = 12;
	localparam logic [2:0] ADDR_NOP     = 3'h0;
	localparam logic [2:0] ADDR_CH_A    = 3'h1;
	localparam logic [2:0] ADDR_ALL     = 3'h5;
	localparam logic [2:0] ADDR_CTRL    = 3'h7;
	localparam int         THERM_BIT    = 0;
	localparam int         PWR_LSB      = 2;
	localparam int         HIZ_BIT      = 6;
	localparam logic [11:0] CTRL_RESET  = 12'h040;
	localparam logic [11:0] CODE_RESET  = 12'h000;
	// timing, pclk at 100 MHz
	localparam int CLK_PERIOD_NS   = 10;
	localparam int SEL_HIGH_MIN_NS = 20;
	localparam int SEL_GAP_CYC     =
		(SEL_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_SCLK_MAX_HZ = 9000000;
	localparam int SCLK_HALF_CYC    =
		(1000000000 + 2 * READ_SCLK_MAX_HZ * CLK_PERIOD_NS - 1)
		/ (2 * READ_SCLK_MAX_HZ * CLK_PERIOD_NS);
	// host register map
	localparam logic [7:0] HOST_FRAME_OFS  = 8'h00;
	localparam logic [7:0] HOST_STATUS_OFS = 8'h04;
	localparam logic [7:0] HOST_PINS_OFS   = 8'h08;
	localparam logic [7:0] HOST_RDATA_OFS  = 8'h0C;
	localparam int         ST_BUSY_BIT     = 0;
	localparam int         ST_ALARM_BIT    = 1;
	localparam int         PIN_RANGE_BIT   = 0;
	localparam int         PIN_LOAD_BIT    = 1;
	localparam int         PIN_CLEAR_BIT   = 2;
	localparam logic [2:0] PINS_RESET      = 3'h7;
endpackage : qdsc_pkg

// ===== src/qdsc_link_if.sv
// serial link between the host controller and the converter
`timescale 1ns/10ps
interface qdsc_link_if;
	logic frame_sel_n;
	logic sclk;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic async_clear_n;
	logic output_load_n;
	logic range_sel;
	logic alarm_n;
	wire  sdo_line;
	// released line shows the inverse, so a late sample reads wrong
	assign sdo_line = sdo_oe ? sdo : ~sdo;
	modport dev_mp (
		input  frame_sel_n, sclk, sdi, async_clear_n, output_load_n,
		input  range_sel,
		output sdo, sdo_oe, alarm_n
	);
	modport host_mp (
		output frame_sel_n, sclk, sdi, async_clear_n, output_load_n,
		output range_sel,
		input  sdo_line, alarm_n
	);
endinterface : qdsc_link_if

// ===== src/qdsc_sync.sv
// two-flop synchroniser, one chain per bit
`timescale 1ns/10ps
module qdsc_sync #(
	parameter int             W    = 1,
	parameter logic [W-1:0]   INIT = '0
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} qdsc_sync_t;
	qdsc_sync_t s_r;
	qdsc_sync_t s_nxt;
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_comb begin
				s_nxt.s1[g] = din[g];
				s_nxt.s2[g] = s_r.s1[g];
			end
		end
	endgenerate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= {INIT, INIT};
		end else begin
			s_r <= s_nxt;
		end
	end
	assign dout = s_r.s2;
endmodule : qdsc_sync

// ===== src/qdsc_device.sv
// converter end: serial frame decoder, registers and load logic
`timescale 1ns/10ps
module qdsc_device
	import qdsc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	qdsc_link_if.dev_mp      link,
	input  wire logic        over_temp,
	output logic      [47:0] dac_code,
	output logic      [3:0]  span_30v,
	output logic      [3:0]  chan_power_on,
	output logic             off_output_hiz,
	output logic             thermal_shutdown
);
	typedef struct packed {
		logic                        sclk_d;
		logic                        sel_d;
		logic                        clr_d;
		logic                        ld_d;
		logic [15:0]                 shift;
		logic [4:0]                  cnt;
		logic                        done;
		logic [3:0][DATA_W-1:0]      inp;
		logic [3:0][DATA_W-1:0]      dac;
		logic [3:0]                  span;
		logic [HIZ_BIT:PWR_LSB]      ctrl;
		logic                        therm;
		logic [DATA_W-1:0]           rd;
		logic                        sdo;
		logic                        oe;
	} qdsc_dev_t;

	qdsc_dev_t s_r;
	qdsc_dev_t s_nxt;

	logic [6:0] raw_in;
	logic [6:0] syn_in;
	logic       s_sclk;
	logic       s_sel_n;
	logic       s_sdi;
	logic       s_clr_n;
	logic       s_ld_n;
	logic       s_range;
	logic       s_temp;

	// every pin and the sensor come from outside pclk
	assign raw_in = {over_temp, link.range_sel, link.output_load_n,
		link.async_clear_n, link.sdi, link.frame_sel_n, link.sclk};
	qdsc_sync #(
		.W    (7),
		.INIT (7'h3A)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (raw_in),
		.dout    (syn_in)
	);
	assign {s_temp, s_range, s_ld_n, s_clr_n, s_sdi, s_sel_n, s_sclk} =
		syn_in;

	function automatic logic [DATA_W-1:0] read_mux(
		input qdsc_dev_t st,
		input logic [2:0] a
	);
		logic [DATA_W-1:0] v;
		v = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (a == 3'(ADDR_CH_A + 3'(i))) begin
				v = st.inp[i];
			end
		end
		if (a == ADDR_CTRL) begin
			v[HIZ_BIT:PWR_LSB] = st.ctrl;
			v[THERM_BIT]       = st.therm;
		end
		return v;
	endfunction : read_mux

	logic              sclk_rise;
	logic              sclk_fall;
	logic              ld_fall;
	logic              clr_fall;
	logic              rw;
	logic [2:0]        addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rsrc;

	// edges found only from sampled clock
	assign sclk_rise = s_sclk & ~s_r.sclk_d;
	assign sclk_fall = ~s_sclk & s_r.sclk_d;
	assign ld_fall   = ~s_ld_n & s_r.ld_d;
	assign clr_fall  = ~s_clr_n & s_r.clr_d;
	assign rw    = s_r.shift[RW_BIT];
	assign addr  = s_r.shift[ADDR_MSB:ADDR_LSB];
	assign wdata = s_r.shift[DATA_W-1:0];
	assign rsrc  = read_mux(s_r, s_r.shift[2:0]);

	always_comb begin
		s_nxt        = s_r;
		s_nxt.sclk_d = s_sclk;
		s_nxt.sel_d  = s_sel_n;
		s_nxt.clr_d  = s_clr_n;
		s_nxt.ld_d   = s_ld_n;
		if (s_sel_n) begin
			s_nxt.cnt  = '0;
			s_nxt.done = 1'b0;
			s_nxt.oe   = 1'b0;
		end else if (!s_r.done) begin
			if (sclk_rise) begin
				s_nxt.shift = {s_r.shift[14:0], s_sdi};
				s_nxt.cnt   = s_r.cnt + 5'h01;
				if (s_r.cnt == RD_START_CLK - 5'h01 && s_r.shift[3]) begin
					s_nxt.oe  = 1'b1;
					s_nxt.sdo = rsrc[DATA_W-1];
					s_nxt.rd  = {rsrc[DATA_W-2:0], 1'b0};
				end else if (s_r.oe) begin
					s_nxt.sdo = s_r.rd[DATA_W-1];
					s_nxt.rd  = {s_r.rd[DATA_W-2:0], 1'b0};
				end
			end
			if (sclk_fall && s_r.cnt == FRAME_BITS) begin
				s_nxt.done = 1'b1;
				s_nxt.oe   = 1'b0;
				if (!rw) begin
					for (int i = 0; i < NUM_CH; i++) begin
						if (addr == 3'(ADDR_CH_A + 3'(i)) ||
							addr == ADDR_ALL) begin
							s_nxt.inp[i] = wdata;
							if (!s_ld_n) begin
								s_nxt.dac[i]  = wdata;
								s_nxt.span[i] = s_range;
							end
						end
					end
					if (addr == ADDR_CTRL) begin
						s_nxt.ctrl = wdata[HIZ_BIT:PWR_LSB];
						if (!wdata[THERM_BIT]) begin
							s_nxt.therm = 1'b0;
						end
					end
				end
			end
		end
		if (ld_fall) begin
			for (int i = 0; i < NUM_CH; i++) begin
				s_nxt.dac[i]  = s_nxt.inp[i];
				s_nxt.span[i] = s_range;
			end
		end
		if (clr_fall) begin
			for (int i = 0; i < NUM_CH; i++) begin
				s_nxt.inp[i] = CODE_RESET;
				s_nxt.dac[i] = CODE_RESET;
			end
		end
		// thermal entry sets flag, set wins
		if (s_temp) begin
			s_nxt.therm = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r        <= '0;
			s_r.sel_d  <= 1'b1;
			s_r.clr_d  <= 1'b1;
			s_r.ld_d   <= 1'b1;
			s_r.ctrl   <= CTRL_RESET[HIZ_BIT:PWR_LSB];
			s_r.span   <= 4'hF;
			s_r.inp    <= {NUM_CH{CODE_RESET}};
			s_r.dac    <= {NUM_CH{CODE_RESET}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dac_code = s_r.dac;
	// per channel span, high is 30 V
	assign span_30v = s_r.span;
	assign chan_power_on    = s_r.ctrl[PWR_LSB+3:PWR_LSB] & {4{~s_r.therm}};
	assign off_output_hiz   = s_r.ctrl[HIZ_BIT];
	assign thermal_shutdown = s_r.therm;
	assign link.alarm_n = ~s_r.therm;
	assign link.sdo     = s_r.sdo;
	assign link.sdo_oe  = s_r.oe;
endmodule : qdsc_device

// ===== src/qdsc_host.sv
// host end: APB register slave driving the serial frame master
`timescale 1ns/10ps
module qdsc_host
	import qdsc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	qdsc_link_if.host_mp     link
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_LOW  = 3'b001,
		H_HIGH = 3'b010,
		H_TAIL = 3'b011,
		H_GAP  = 3'b100
	} qdsc_hstate_t;

	typedef struct packed {
		qdsc_hstate_t      st;
		logic [15:0]       word;
		logic              go;
		logic              nop_pend;
		logic [2:0]        pins;
		logic              range;
		logic [3:0]        div;
		logic [4:0]        bitn;
		logic [DATA_W-1:0] rd;
		logic              sclk;
		logic              sel_n;
		logic              sdi;
	} qdsc_host_t;

	qdsc_host_t s_r;
	qdsc_host_t s_nxt;
	logic [1:0] syn;
	logic       wr;
	logic       mapped;

	qdsc_sync #(
		.W    (2),
		.INIT (2'h3)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({link.alarm_n, link.sdo_line}),
		.dout    (syn)
	);

	assign wr     = psel & penable & pwrite;
	assign mapped = paddr == HOST_FRAME_OFS || paddr == HOST_STATUS_OFS ||
		paddr == HOST_PINS_OFS || paddr == HOST_RDATA_OFS;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	always_comb begin
		prdata = '0;
		case (paddr)
			HOST_FRAME_OFS:  prdata[15:0] = s_r.word;
			HOST_STATUS_OFS: begin
				prdata[ST_BUSY_BIT]  = s_r.go || s_r.st != H_IDLE;
				prdata[ST_ALARM_BIT] = ~syn[1];
			end
			HOST_PINS_OFS:   prdata[2:0] = s_r.pins;
			HOST_RDATA_OFS:  prdata[DATA_W-1:0] = s_r.rd;
			default:         prdata = '0;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		if (wr && paddr == HOST_PINS_OFS) begin
			s_nxt.pins = pwdata[2:0];
		end
		// busy host ignores a new frame word
		if (wr && paddr == HOST_FRAME_OFS && !s_r.go && s_r.st == H_IDLE) begin
			s_nxt.word = pwdata[15:0];
			s_nxt.go   = 1'b1;
		end
		case (s_r.st)
			H_IDLE: begin
				if (s_r.go) begin
					s_nxt.go    = 1'b0;
					s_nxt.sel_n = 1'b0;
					s_nxt.sdi   = s_r.word[RW_BIT];
					s_nxt.bitn  = '0;
					// half period keeps reads under limit
					s_nxt.div   = 4'(SCLK_HALF_CYC - 1);
					s_nxt.st    = H_LOW;
					// control write gets a trailing nop
					s_nxt.nop_pend = ~s_r.word[RW_BIT] &&
						s_r.word[ADDR_MSB:ADDR_LSB] == ADDR_CTRL;
				end else begin
					// range moves only between frames
					// held while a frame starts so it never moves with select
					s_nxt.range = s_r.pins[PIN_RANGE_BIT];
				end
			end
			H_LOW: begin
				s_nxt.div = s_r.div - 4'h1;
				if (s_r.div == 4'h0) begin
					s_nxt.sclk = 1'b1;
					s_nxt.bitn = s_r.bitn + 5'h01;
					s_nxt.div  = 4'(SCLK_HALF_CYC - 1);
					s_nxt.st   = H_HIGH;
				end
			end
			H_HIGH: begin
				s_nxt.div = s_r.div - 4'h1;
				if (s_r.div == 4'h0) begin
					s_nxt.sclk = 1'b0;
					s_nxt.div  = 4'(SCLK_HALF_CYC - 1);
					if (s_r.bitn >= RD_START_CLK && s_r.word[RW_BIT]) begin
						s_nxt.rd = {s_r.rd[DATA_W-2:0], syn[0]};
					end
					if (s_r.bitn == FRAME_BITS) begin
						s_nxt.st = H_TAIL;
					end else begin
						s_nxt.sdi = s_r.word[4'(4'hF - s_r.bitn[3:0])];
						s_nxt.st  = H_LOW;
					end
				end
			end
			H_TAIL: begin
				s_nxt.div = s_r.div - 4'h1;
				if (s_r.div == 4'h0) begin
					s_nxt.sel_n = 1'b1;
					s_nxt.div   = 4'(SEL_GAP_CYC - 1);
					s_nxt.st    = H_GAP;
				end
			end
			H_GAP: begin
				// select stays high for the gap
				s_nxt.div = s_r.div - 4'h1;
				if (s_r.div == 4'h0) begin
					s_nxt.st = H_IDLE;
					if (s_r.nop_pend) begin
						s_nxt.word     = {1'b0, ADDR_NOP, 12'h000};
						s_nxt.go       = 1'b1;
						s_nxt.nop_pend = 1'b0;
					end
				end
			end
			default: s_nxt.st = H_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r       <= '0;
			s_r.st    <= H_IDLE;
			s_r.pins  <= PINS_RESET;
			s_r.range <= PINS_RESET[PIN_RANGE_BIT];
			s_r.sel_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.frame_sel_n   = s_r.sel_n;
	assign link.sclk          = s_r.sclk;
	assign link.sdi           = s_r.sdi;
	assign link.range_sel     = s_r.range;
	assign link.output_load_n = s_r.pins[PIN_LOAD_BIT];
	assign link.async_clear_n = s_r.pins[PIN_CLEAR_BIT];
endmodule : qdsc_host

// ===== verification/qdsc_props.sv
// link checker for the converter serial link
`timescale 1ns/10ps
module qdsc_props
	import qdsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic frame_sel_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic async_clear_n,
	input wire logic output_load_n,
	input wire logic range_sel,
	input wire logic alarm_n
);
	logic       sclk_q;
	logic [4:0] rise_cnt;
	logic [3:0] hold_cnt;
	// raw sclk rises in this frame; sdo_oe lags by the sync delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_q   <= 1'b0;
			rise_cnt <= 5'h00;
			hold_cnt <= 4'h0;
		end else begin
			sclk_q <= sclk;
			if (sclk != sclk_q)
				hold_cnt <= 4'h0;
			else if (hold_cnt != 4'hF)
				hold_cnt <= hold_cnt + 4'h1;
			if (frame_sel_n)
				rise_cnt <= 5'h00;
			else if (sclk && !sclk_q)
				rise_cnt <= rise_cnt + 5'h01;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_sel_held;
		frame_sel_n ##1 frame_sel_n;
	endsequence
	chk_sel_gap: assert property ($rose(frame_sel_n) |-> s_sel_held)
		else $error("select high gap too short");
	chk_frame_len: assert property ($rose(frame_sel_n) |-> rise_cnt == 5'h10)
		else $error("frame clock count not sixteen");
	chk_sdi_setup: assert property ($rose(sclk) |-> $stable(sdi))
		else $error("data changed at clock rise");
	chk_sclk_idle: assert property (frame_sel_n |-> !sclk)
		else $error("serial clock runs between frames");
	chk_oe_start: assert property ($rose(sdo_oe) |-> rise_cnt == 5'h05)
		else $error("data output enabled on wrong clock");
	chk_oe_early: assert property (sdo_oe && !frame_sel_n |-> rise_cnt >= 5'h05)
		else $error("data output driven too early");
	chk_oe_off: assert property (frame_sel_n [*4] |-> !sdo_oe)
		else $error("data output driven while idle");
	// alarm may only clear as the result of a frame
	chk_alarm_hold: assert property ($rose(alarm_n) |-> !$past(frame_sel_n, 8))
		else $error("alarm released without a frame");
	chk_range_quiet: assert property (!frame_sel_n |-> $stable(range_sel))
		else $error("range changed during a frame");
	chk_sclk_half: assert property ($changed(sclk) |->
		int'(hold_cnt) >= SCLK_HALF_CYC - 1)
		else $error("serial clock half period too short");
endmodule : qdsc_props

// ===== verification/qdsc_tb_top.sv
// testbench joining host and converter ends over the link
`timescale 1ns/10ps
module qdsc_tb_top
	import qdsc_pkg::*;
;
	logic        pclk      = 1'b0;
	logic        presetn   = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h0;
	logic        over_temp = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [47:0] dac_code;
	logic [3:0]  span_30v;
	logic [3:0]  chan_power_on;
	logic        off_output_hiz;
	logic        thermal_shutdown;
	logic [31:0] rd;
	logic        err;
	int          n_errors    = 0;
	int          comparisons = 0;
	always #(CLK_PERIOD_NS / 2) pclk = ~pclk;
	qdsc_link_if u_qdsc_link_if ();
	qdsc_host u_qdsc_host (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.link    (u_qdsc_link_if)
	);
	qdsc_device u_qdsc_device (
		.pclk             (pclk),
		.presetn          (presetn),
		.link             (u_qdsc_link_if),
		.over_temp        (over_temp),
		.dac_code         (dac_code),
		.span_30v         (span_30v),
		.chan_power_on    (chan_power_on),
		.off_output_hiz   (off_output_hiz),
		.thermal_shutdown (thermal_shutdown)
	);
	qdsc_props u_qdsc_props (
		.pclk          (pclk),
		.presetn       (presetn),
		.frame_sel_n   (u_qdsc_link_if.frame_sel_n),
		.sclk          (u_qdsc_link_if.sclk),
		.sdi           (u_qdsc_link_if.sdi),
		.sdo           (u_qdsc_link_if.sdo),
		.sdo_oe        (u_qdsc_link_if.sdo_oe),
		.async_clear_n (u_qdsc_link_if.async_clear_n),
		.output_load_n (u_qdsc_link_if.output_load_n),
		.range_sel     (u_qdsc_link_if.range_sel),
		.alarm_n       (u_qdsc_link_if.alarm_n)
	);
	task complete_run;
		$display("mismatches %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	task chk(input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			n_errors++;
			complete_run();
		end
	endtask : apb
	task wait_idle;
		int n;
		for (n = 0; n < 400; n++) begin
			apb(1'b0, HOST_STATUS_OFS, 32'h0);
			if (rd[ST_BUSY_BIT] === 1'b0)
				break;
		end
		if (n == 400) begin
			n_errors++;
			complete_run();
		end
	endtask : wait_idle
	// second poll covers the automatic frame after a control write
	task send(input logic [15:0] w);
		wait_idle();
		apb(1'b1, HOST_FRAME_OFS, {16'h0, w});
		wait_idle();
		repeat (8) @(posedge pclk);
		wait_idle();
	endtask : send
	task rdreg(input logic [2:0] a);
		send({1'b1, a, 12'h000});
		apb(1'b0, HOST_RDATA_OFS, 32'h0);
	endtask : rdreg
	task pins(input logic [2:0] p);
		apb(1'b1, HOST_PINS_OFS, {29'h0, p});
		repeat (8) @(posedge pclk);
	endtask : pins
	task t_reset;
		chk(dac_code, 48'h0);
		chk(span_30v, 4'hF);
		chk(chan_power_on, 4'h0);
		chk(off_output_hiz, 1'b1);
		rdreg(ADDR_CTRL);
		chk(rd[11:0], CTRL_RESET);
		$display("test reset done");
	endtask : t_reset
	task t_sync;
		pins(3'h5);
		send(16'h2123);
		chk(dac_code[23:12], 12'h123);
		chk(dac_code[11:0], 12'h000);
		rdreg(3'h2);
		chk(rd[11:0], 12'h123);
		send(16'h5ABC);
		chk(dac_code, {4{12'hABC}});
		send(16'h0FFF);
		send(16'h6FFF);
		chk(dac_code, {4{12'hABC}});
		rdreg(3'h3);
		chk(rd[11:0], 12'hABC);
		rdreg(3'h6);
		chk(rd[11:0], 12'h000);
		$display("test sync done");
	endtask : t_sync
	task t_async;
		pins(3'h7);
		send(16'h1800);
		chk(dac_code[11:0], 12'hABC);
		pins(3'h6);
		chk(span_30v, 4'hF);
		pins(3'h4);
		chk(dac_code, {{3{12'hABC}}, 12'h800});
		chk(span_30v, 4'h0);
		$display("test async done");
	endtask : t_async
	task t_clear;
		pins(3'h3);
		chk(dac_code, 48'h0);
		pins(3'h7);
		rdreg(ADDR_CH_A);
		chk(rd[11:0], CODE_RESET);
		$display("test clear done");
	endtask : t_clear
	task t_ctrl;
		send(16'h703C);
		chk(chan_power_on, 4'hF);
		chk(off_output_hiz, 1'b0);
		over_temp <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(thermal_shutdown, 1'b1);
		chk(chan_power_on, 4'h0);
		apb(1'b0, HOST_STATUS_OFS, 32'h0);
		chk(rd[ST_ALARM_BIT], 1'b1);
		over_temp <= 1'b0;
		repeat (8) @(posedge pclk);
		chk(thermal_shutdown, 1'b1);
		rdreg(ADDR_CTRL);
		chk(rd[11:0], 12'h03D);
		send(16'h703C);
		chk(thermal_shutdown, 1'b0);
		chk(chan_power_on, 4'hF);
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		$display("test control done");
	endtask : t_ctrl
	// second reset in mid-run must restore the power-on state
	task t_rerun;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		t_reset();
		$display("test mid-run reset done");
	endtask : t_rerun
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		t_reset();
		t_sync();
		t_async();
		t_clear();
		t_ctrl();
		t_rerun();
		complete_run();
	end
endmodule : qdsc_tb_top
